// [src/ffm_fault_manager.sv]
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module ffm_fault_manager
  import ffm_pkg::*;
#(
  parameter int BROWNOUT_CYCLES    = BROWNOUT_CYC,
  parameter int RESET_LONG_CYCLES  = 25000000,
  parameter int RESET_SHORT_CYCLES = 2500000
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire ffm_variant_t variant,
  input  wire logic         ac_present,
  input  wire logic [3:0]   prog_code,
  input  wire logic         prog_code_valid,
  input  wire logic         pwm_period_tick,
  input  wire logic         vdd_ov_raw,
  input  wire logic         vdd_uv_raw,
  input  wire logic         ac_brownout_raw,
  input  wire logic         over_temp_raw,
  input  wire logic         shutdown_input_pin,
  input  wire logic         output_ov_raw,
  input  wire logic         xcap_discharge_req,
  input  wire logic         aux_voltage_sense_pin_pin_fault,
  input  wire logic         cs_pin_fault,
  input  wire logic         gate_drive_short,
  input  wire logic         internal_fault,
  input  wire logic [15:0]  load_sq,
  input  wire logic         supply_at_reset,
  input  wire logic         supply_below_latch_lo,
  input  wire logic         supply_above_latch_hi,
  output logic              pwm_enable,
  output logic              cycle_terminate,
  output logic              test_voltage_en,
  output logic              low_power_mode,
  output logic              vdd_discharge_en,
  output logic              hv_source_en,
  output logic              supply_ovp_low_sel,
  output logic              fault_latched,
  output logic [7:0]        trip_level_pct,
  output logic [15:0]       timer_tc_ms,
  output logic [7:0]        cc_limit_pct,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);

  if (BROWNOUT_CYCLES < 1 || BROWNOUT_CYCLES >= (1 << FCNT_W)) begin : g_chk_brown
    $error("brownout count out of range");
  end
  if (RESET_LONG_CYCLES < 1 || RESET_LONG_CYCLES >= (1 << DCNT_W) ||
      RESET_SHORT_CYCLES < 1 || RESET_SHORT_CYCLES >= (1 << DCNT_W)) begin : g_chk_dly
    $error("restart delay count out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_PROG, ST_CHECK, ST_RUN, ST_DELAY, ST_DISCH,
                            ST_LATCH} ffm_state_t;

  ffm_state_t           st_reg,    st_next;
  logic [3:0]           code_reg,  code_next;
  logic [DCNT_W-1:0]    dcnt_reg,  dcnt_next;
  logic                 short_reg, short_next;
  logic                 hv_reg,    hv_next;
  logic                 latch_reg, latch_next;
  logic                 term_reg,  term_next;
  logic [7:0]           trip_reg,  trip_next;
  logic [15:0]          tc_reg,    tc_next;
  logic [7:0]           cc_reg,    cc_next;
  logic                 ovpl_reg,  ovpl_next;
  logic [N_FAULT-1:0]   cap;
  logic [N_FAULT-1:0]   fv;
  logic [N_FILT-1:0]    raw;
  logic [N_FAULT-1:0]   lmask;
  logic                 go_latch;
  logic                 go_short;
  logic                 run_en;
  logic [DCNT_W-1:0]    dlim;

  // filtered sources, shutdown pin is active low
  assign raw = {output_ov_raw, ~shutdown_input_pin, over_temp_raw, ac_brownout_raw,
                vdd_uv_raw, vdd_ov_raw};

  // persistence filters
  logic [FCNT_W-1:0] fc_reg [N_FILT];
  logic [FCNT_W-1:0] fc_next[N_FILT];
  logic [1:0]        fp_reg [N_FILT];
  logic [1:0]        fp_next[N_FILT];

  for (genvar i = 0; i < N_FILT; i++) begin : g_filt
    localparam logic [FCNT_W-1:0] LIM =
      (i == F_BROWN) ? FCNT_W'(BROWNOUT_CYCLES) : FCNT_W'(FILT_CYC);
    localparam bit NEED_P = (i != F_BROWN);
    always_comb
    begin
      fc_next[i] = fc_reg[i];
      fp_next[i] = fp_reg[i];
      if (!raw[i])
      begin
        fc_next[i] = '0;
        fp_next[i] = '0;
      end
      else
      begin
        if (fc_reg[i] != LIM)
          fc_next[i] = fc_reg[i] + 1'b1;
        if (pwm_period_tick && fp_reg[i] != 2'(FILT_PERIODS))
          fp_next[i] = fp_reg[i] + 1'b1;
      end
    end
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        fc_reg[i] <= '0;
        fp_reg[i] <= '0;
      end
      else
      begin
        fc_reg[i] <= fc_next[i];
        fp_reg[i] <= fp_next[i];
      end
    end
    assign fv[i] = raw[i] && (fc_reg[i] == LIM) &&
                   (!NEED_P || fp_reg[i] == 2'(FILT_PERIODS));
  end

  // overload timer: first-order tracking of load squared
  localparam int OLT_W = 16 + OLT_FR;
  logic [OLT_W-1:0]   olt_reg, olt_next;
  logic signed [OLT_W:0] olt_diff;
  logic signed [OLT_W:0] olt_sum;
  logic [15:0]        trip_sq;
  logic               olt_trip;

  always_comb
  begin
    olt_diff = $signed({1'b0, load_sq, {OLT_FR{1'b0}}}) - $signed({1'b0, olt_reg});
    olt_sum  = $signed({1'b0, olt_reg}) + (olt_diff >>> OLT_SHIFT[code_reg]);
    olt_next = olt_reg;
    if (variant == FFM_VAR_FULL && pwm_period_tick)
      olt_next = olt_sum[OLT_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      olt_reg <= '0;
    else
      olt_reg <= olt_next;
  end

  assign trip_sq  = 16'(trip_reg * trip_reg);
  assign olt_trip = (variant == FFM_VAR_FULL) && (st_reg == ST_RUN) &&
                    (olt_reg[OLT_W-1:OLT_FR] > trip_sq);

  // unfiltered overload, start-up, diagnostic and X-cap discharge faults
  assign fv[F_OLT]    = olt_trip;
  assign fv[F_AUX_VOLTAGE_SENSE_PIN] = aux_voltage_sense_pin_pin_fault && st_reg == ST_CHECK;
  assign fv[F_CS]     = cs_pin_fault && st_reg == ST_CHECK;
  assign fv[F_DRV]    = gate_drive_short && st_reg == ST_CHECK;
  assign fv[F_INT]    = internal_fault;
  assign fv[F_XCAP]   = xcap_discharge_req;

  always_comb
  begin
    if (variant == FFM_VAR_FULL)
      lmask = LATCH_MASK_FULL;
    else if (variant == FFM_VAR_CC)
      lmask = LATCH_MASK_CC;
    else
      lmask = LATCH_MASK_LOW;
  end

  assign go_latch = |(fv & lmask);
  assign go_short = |(fv & SHORT_MASK);
  assign dlim     = short_reg ? DCNT_W'(RESET_SHORT_CYCLES) : DCNT_W'(RESET_LONG_CYCLES);

  // main sequence
  always_comb
  begin
    st_next    = st_reg;
    code_next  = code_reg;
    dcnt_next  = dcnt_reg;
    short_next = short_reg;
    hv_next    = hv_reg;
    latch_next = latch_reg;
    term_next  = 1'b0;
    cap        = '0;
    case (st_reg)
      ST_IDLE:
      begin
        latch_next = 1'b0;
        hv_next    = 1'b0;
        if (ac_present && run_en)
          st_next = ST_PROG;
      end
      ST_PROG:
      begin
        if (prog_code_valid)
        begin
          code_next = (prog_code > CODE_MAX) ? 4'h0 : prog_code;
          st_next   = ST_CHECK;
        end
      end
      ST_CHECK, ST_RUN:
      begin
        if (|fv)
        begin
          cap       = fv;
          term_next = (st_reg == ST_RUN);
          dcnt_next = '0;
          if (go_latch)
          begin
            st_next    = ST_LATCH;
            latch_next = 1'b1;
          end
          else
          begin
            st_next    = ST_DELAY;
            short_next = go_short;
          end
        end
        else if (st_reg == ST_CHECK)
          st_next = ST_RUN;
        else if (!run_en)
          st_next = ST_IDLE;
      end
      ST_DELAY:
      begin
        dcnt_next = dcnt_reg + 1'b1;
        if (dcnt_reg == dlim - 1'b1)
        begin
          dcnt_next = '0;
          st_next   = ST_DISCH;
        end
      end
      ST_DISCH:
      begin
        if (supply_at_reset)
          st_next = ST_PROG;
      end
      ST_LATCH:
      begin
        if (supply_below_latch_lo)
          hv_next = 1'b1;
        else if (supply_above_latch_hi)
          hv_next = 1'b0;
        if (!ac_present)
        begin
          st_next    = ST_IDLE;
          latch_next = 1'b0;
          hv_next    = 1'b0;
        end
      end
      default:
        st_next = ST_IDLE;
    endcase
    if (variant == FFM_VAR_FULL)
    begin
      trip_next = TRIP_PCT[code_next];
      tc_next   = TC_MS[code_next];
      cc_next   = CC_FULL;
    end
    else
    begin
      trip_next = '0;
      tc_next   = '0;
      cc_next   = CC_PCT[code_next];
    end
    ovpl_next = (variant == FFM_VAR_LOWTH);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_reg    <= ST_IDLE;
      code_reg  <= '0;
      dcnt_reg  <= '0;
      short_reg <= 1'b0;
      hv_reg    <= 1'b0;
      latch_reg <= 1'b0;
      term_reg  <= 1'b0;
      trip_reg  <= '0;
      tc_reg    <= '0;
      cc_reg    <= '0;
      ovpl_reg  <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      code_reg  <= code_next;
      dcnt_reg  <= dcnt_next;
      short_reg <= short_next;
      hv_reg    <= hv_next;
      latch_reg <= latch_next;
      term_reg  <= term_next;
      trip_reg  <= trip_next;
      tc_reg    <= tc_next;
      cc_reg    <= cc_next;
      ovpl_reg  <= ovpl_next;
    end
  end

  // drive outputs, registered from the next state
  logic [5:0] pin_reg, pin_next;

  always_comb
  begin
    pin_next    = '0;
    pin_next[0] = (st_next == ST_RUN);
    pin_next[1] = (st_next == ST_PROG);
    pin_next[2] = (st_next == ST_DELAY) || (st_next == ST_DISCH) ||
                  (st_next == ST_LATCH);
    pin_next[3] = (st_next == ST_DISCH);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pin_reg <= '0;
    else
      pin_reg <= pin_next;
  end

  assign pwm_enable         = pin_reg[0];
  assign test_voltage_en    = pin_reg[1];
  assign low_power_mode     = pin_reg[2];
  assign vdd_discharge_en   = pin_reg[3];
  assign hv_source_en       = hv_reg;
  assign cycle_terminate    = term_reg;
  assign fault_latched      = latch_reg;
  assign supply_ovp_low_sel = ovpl_reg;
  assign trip_level_pct     = trip_reg;
  assign timer_tc_ms        = tc_reg;
  assign cc_limit_pct       = cc_reg;

  // register bus slave
  logic               awh_reg, awh_next;
  logic               wh_reg,  wh_next;
  logic [7:0]         awa_reg, awa_next;
  logic [31:0]        wd_reg,  wd_next;
  logic [3:0]         ws_reg,  ws_next;
  logic               bv_reg,  bv_next;
  logic [1:0]         br_reg,  br_next;
  logic               rv_reg,  rv_next;
  logic [31:0]        rd_reg,  rd_next;
  logic [1:0]         rr_reg,  rr_next;
  logic [0:0]         ctrl_reg, ctrl_next;
  logic [N_FAULT-1:0] flt_reg, flt_next;
  logic [N_FAULT-1:0] clr;
  logic               wr_go;

  assign s_axi_awready = !awh_reg;
  assign s_axi_wready  = !wh_reg;
  assign s_axi_arready = !rv_reg;
  assign wr_go         = awh_reg && wh_reg && !bv_reg;
  assign run_en        = ctrl_reg[0];

  always_comb
  begin
    awh_next  = awh_reg;
    wh_next   = wh_reg;
    awa_next  = awa_reg;
    wd_next   = wd_reg;
    ws_next   = ws_reg;
    bv_next   = bv_reg && !s_axi_bready;
    br_next   = br_reg;
    rv_next   = rv_reg && !s_axi_rready;
    rd_next   = rd_reg;
    rr_next   = rr_reg;
    ctrl_next = ctrl_reg;
    clr       = '0;
    if (s_axi_awvalid && !awh_reg)
    begin
      awh_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wh_reg)
    begin
      wh_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (wr_go)
    begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = RESP_OKAY;
      if (awa_reg == OFS_CTRL)
      begin
        if (ws_reg[0])
          ctrl_next = wd_reg[0:0];
      end
      else if (awa_reg == OFS_FAULT)
        clr = wd_reg[N_FAULT-1:0] & {{4{ws_reg[1]}}, {8{ws_reg[0]}}};
      else if (awa_reg == OFS_STATUS || awa_reg == OFS_SETTING || awa_reg == OFS_OLT)
        br_next = RESP_OKAY;
      else
        br_next = RESP_SLVERR;
    end
    if (s_axi_arvalid && !rv_reg)
    begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL)
        rd_next = {31'h0, ctrl_reg};
      else if (s_axi_araddr == OFS_STATUS)
        rd_next = {25'h0, 3'(st_reg), pin_reg[3:0]} | {27'h0, latch_reg, 4'h0};
      else if (s_axi_araddr == OFS_FAULT)
        rd_next = {20'h0, flt_reg};
      else if (s_axi_araddr == OFS_SETTING)
        rd_next = {cc_reg, trip_reg, 12'h0, code_reg};
      else if (s_axi_araddr == OFS_OLT)
        rd_next = {16'h0, olt_reg[OLT_W-1:OLT_FR]};
      else
      begin
        rd_next = '0;
        rr_next = RESP_SLVERR;
      end
    end
    // a new fault wins over a clear in the same cycle
    flt_next = (flt_reg & ~clr) | cap;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      awh_reg  <= 1'b0;
      wh_reg   <= 1'b0;
      awa_reg  <= '0;
      wd_reg   <= '0;
      ws_reg   <= '0;
      bv_reg   <= 1'b0;
      br_reg   <= RESP_OKAY;
      rv_reg   <= 1'b0;
      rd_reg   <= '0;
      rr_reg   <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
      flt_reg  <= '0;
    end
    else
    begin
      awh_reg  <= awh_next;
      wh_reg   <= wh_next;
      awa_reg  <= awa_next;
      wd_reg   <= wd_next;
      ws_reg   <= ws_next;
      bv_reg   <= bv_next;
      br_reg   <= br_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      rr_reg   <= rr_next;
      ctrl_reg <= ctrl_next;
      flt_reg  <= flt_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp  = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata  = rd_reg;
  assign s_axi_rresp  = rr_reg;

endmodule // ffm_fault_manager

// [src/ffm_pkg.sv]
package ffm_pkg;
  localparam int CLK_NS        = 40;
  localparam int FILT_NS       = 125000;
  localparam int FILT_CYC      = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_PERIODS  = 2;
  localparam int BROWNOUT_MS   = 40;
  localparam int NS_PER_MS     = 1000000;
  localparam int BROWNOUT_CYC  = BROWNOUT_MS * NS_PER_MS / CLK_NS;
  localparam int TEST_MV       = 400;
  localparam int OVP_MV_STD    = 17500;
  localparam int OVP_MV_LOW    = 14850;
  localparam int FCNT_W        = 20;
  localparam int DCNT_W        = 26;
  localparam int OLT_FR        = 10;
  localparam int N_FILT        = 6;
  localparam int N_FAULT       = 12;
  localparam logic [3:0] CODE_MAX = 4'h8;

  typedef enum logic [1:0] {FFM_VAR_FULL, FFM_VAR_CC, FFM_VAR_LOWTH} ffm_variant_t;

  // fault vector bit positions
  localparam int F_VDD_OV  = 0;
  localparam int F_VDD_UV  = 1;
  localparam int F_BROWN   = 2;
  localparam int F_TEMP    = 3;
  localparam int F_SD      = 4;
  localparam int F_OUT_OV  = 5;
  localparam int F_OLT     = 6;
  localparam int F_AUX_VOLTAGE_SENSE_PIN  = 7;
  localparam int F_CS      = 8;
  localparam int F_DRV     = 9;
  localparam int F_INT     = 10;
  localparam int F_XCAP    = 11;
  localparam logic [N_FAULT-1:0] LATCH_MASK_FULL = 12'h7B9;
  localparam logic [N_FAULT-1:0] LATCH_MASK_CC   = 12'h780;
  localparam logic [N_FAULT-1:0] LATCH_MASK_LOW  = 12'h000;
  localparam logic [N_FAULT-1:0] SHORT_MASK      = 12'h804;

  localparam logic [0:8][7:0]  TRIP_PCT  = {8'hA0, 8'hA0, 8'hA0, 8'h87, 8'h87, 8'h87,
                                            8'h6E, 8'h6E, 8'h6E};
  localparam logic [0:8][15:0] TC_MS     = {16'h03E8, 16'h01F4, 16'h0096, 16'h03E8,
                                            16'h01F4, 16'h0096, 16'h03E8, 16'h01F4,
                                            16'h0096};
  localparam logic [0:8][3:0]  OLT_SHIFT = {4'hA, 4'h9, 4'h7, 4'hA, 4'h9, 4'h7,
                                            4'hA, 4'h9, 4'h7};
  localparam logic [0:8][7:0]  CC_PCT    = {8'h64, 8'h5A, 8'h50, 8'h4B, 8'h46, 8'h41,
                                            8'h3C, 8'h37, 8'h32};
  localparam logic [7:0]       CC_FULL   = 8'h64;

  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_FAULT   = 8'h08;
  localparam logic [7:0]  OFS_SETTING = 8'h0C;
  localparam logic [7:0]  OFS_OLT     = 8'h10;
  localparam logic [0:0]  CTRL_RESET  = 1'h1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// [tb/ffm_ext_power_stage.sv]
module ffm_ext_power_stage
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] code,
  input  wire logic       test_voltage_en,
  input  wire logic       low_power_mode,
  input  wire logic       vdd_discharge_en,
  input  wire logic       hv_source_en,
  output logic [3:0]      prog_code,
  output logic            prog_code_valid,
  output logic            pwm_period_tick,
  output logic            supply_at_reset,
  output logic            supply_below_latch_lo,
  output logic            supply_above_latch_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  int         lvl;
  logic [5:0] div;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      lvl <= 100;
      div <= 6'h00;
      prog_code_valid <= 1'b0;
      prog_code <= 4'h0;
    end
    else
    begin
      div <= div + 6'h01;
      prog_code_valid <= test_voltage_en;
      prog_code <= test_voltage_en ? code : ~prog_code;
      if (vdd_discharge_en || (low_power_mode && !hv_source_en))
        lvl <= (lvl > 0) ? lvl - 1 : 0;
      else if (lvl < 100)
        lvl <= lvl + 1;
    end
  end
  assign pwm_period_tick = (div == 6'h3F);
  assign supply_at_reset = (lvl <= 10);
  assign supply_below_latch_lo = (lvl < 40);
  assign supply_above_latch_hi = (lvl > 70);
endmodule // ffm_ext_power_stage

// [tb/ffm_fault_manager_monitor.sv]
module ffm_fault_manager_mon
  import ffm_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire ffm_variant_t variant,
  input wire logic         ac_present,
  input wire logic         aux_voltage_sense_pin_pin_fault,
  input wire logic         cs_pin_fault,
  input wire logic         gate_drive_short,
  input wire logic         supply_below_latch_lo,
  input wire logic         pwm_enable,
  input wire logic         cycle_terminate,
  input wire logic         test_voltage_en,
  input wire logic         low_power_mode,
  input wire logic         vdd_discharge_en,
  input wire logic         hv_source_en,
  input wire logic         supply_ovp_low_sel,
  input wire logic         fault_latched,
  input wire logic [7:0]   trip_level_pct,
  input wire logic [15:0]  timer_tc_ms,
  input wire logic [7:0]   cc_limit_pct
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_test; test_voltage_en |-> !pwm_enable; endproperty
  a_test: assert property (p_test) else $error("pwm during test");
  property p_term;
    cycle_terminate |-> $past(pwm_enable) && !pwm_enable && low_power_mode ##1 !cycle_terminate;
  endproperty
  a_term: assert property (p_term) else $error("bad terminate");
  property p_start;
    $rose(pwm_enable) |-> !$past(gate_drive_short) && !$past(aux_voltage_sense_pin_pin_fault)
      && !$past(cs_pin_fault);
  endproperty
  a_start: assert property (p_start) else $error("run despite pin fault");
  property p_latch; fault_latched |-> !pwm_enable && low_power_mode; endproperty
  a_latch: assert property (p_latch) else $error("latched but active");
  property p_hv; fault_latched && ac_present && supply_below_latch_lo |=> hv_source_en; endproperty
  a_hv: assert property (p_hv) else $error("hold source off");
  property p_ac; fault_latched && !ac_present |=> !fault_latched; endproperty
  a_ac: assert property (p_ac) else $error("latch kept");
  property p_ovp;
    $past(rst_n) |-> supply_ovp_low_sel == ($past(variant) == FFM_VAR_LOWTH);
  endproperty
  a_ovp: assert property (p_ovp) else $error("ovp select wrong");
  property p_low; variant == FFM_VAR_LOWTH |-> !fault_latched; endproperty
  a_low: assert property (p_low) else $error("latch on low variant");
  property p_hold;
    pwm_enable && $past(pwm_enable) |-> $stable(trip_level_pct) && $stable(timer_tc_ms)
      && $stable(cc_limit_pct);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved");
  property p_disch; vdd_discharge_en |-> low_power_mode && !fault_latched; endproperty
  a_disch: assert property (p_disch) else $error("bad discharge");
  c_run: cover property ($rose(pwm_enable));
  c_latch: cover property ($rose(fault_latched));
  c_disch: cover property ($rose(vdd_discharge_en));
endmodule // ffm_fault_manager_mon

bind ffm_fault_manager ffm_fault_manager_mon u_mon (.*);

// [tb/ffm_fault_manager_tb_top.sv]
module ffm_fault_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ffm_pkg::*;
  localparam int LONG = 40;
  localparam int SHORT = 10;
  logic mclk, rst_n, ac_present, prog_code_valid, pwm_period_tick, supply_at_reset;
  logic supply_below_latch_lo, supply_above_latch_hi, pwm_enable, cycle_terminate;
  logic test_voltage_en, low_power_mode, vdd_discharge_en, hv_source_en;
  logic supply_ovp_low_sel, fault_latched;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] code, prog_code, s_axi_wstrb;
  logic [7:0] trip_level_pct, cc_limit_pct, s_axi_awaddr, s_axi_araddr;
  logic [15:0] timer_tc_ms, load_sq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [11:0] flt;
  ffm_variant_t variant;
  int miscompares = 0;
  int n_compared = 0;
  wire logic vdd_ov_raw = flt[F_VDD_OV];
  wire logic vdd_uv_raw = flt[F_VDD_UV];
  wire logic ac_brownout_raw = flt[F_BROWN];
  wire logic over_temp_raw = flt[F_TEMP];
  wire logic shutdown_input_pin = !flt[F_SD];
  wire logic output_ov_raw = flt[F_OUT_OV];
  wire logic aux_voltage_sense_pin_pin_fault = flt[F_AUX_VOLTAGE_SENSE_PIN];
  wire logic cs_pin_fault = flt[F_CS];
  wire logic gate_drive_short = flt[F_DRV];
  wire logic internal_fault = flt[F_INT];
  wire logic xcap_discharge_req = flt[F_XCAP];
  ffm_fault_manager #(.BROWNOUT_CYCLES(50), .RESET_LONG_CYCLES(LONG),
    .RESET_SHORT_CYCLES(SHORT)) dut (.*);
  ffm_ext_power_stage u_ext (.*);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return pwm_enable;
      1: return fault_latched;
      2: return vdd_discharge_en;
      3: return low_power_mode;
      default: return hv_source_en;
    endcase
  endfunction
  task automatic wt(input int s, input logic v, input int lim, output int k);
    k = 0;
    do
    begin
      @(negedge mclk);
      k++;
    end
    while (sig(s) !== v && k < lim);
    chk($sformatf("signal %0d", s), 32'(v), 32'(sig(s)));
    @(posedge mclk);
  endtask
  task automatic boot(input int v, input int c);
    rst_n <= 1'b0;
    variant <= ffm_variant_t'(v);
    code <= 4'(c);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask
  initial
  begin
    int n;
    int f;
    logic [31:0] d;
    logic [1:0] r;
    rst_n = 1'b0;
    variant = FFM_VAR_FULL;
    ac_present = 1'b1;
    code = 4'h0;
    flt = 12'h000;
    load_sq = 16'h0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
    @(posedge mclk);
    for (int v = 0; v < 2; v++)
      for (int c = 0; c < 9; c++)
      begin
        boot(v, c);
        wt(0, 1'b1, 100, n);
        if (v == 0)
        begin
          chk("trip", 160 - 25 * (c / 3), trip_level_pct);
          chk("tc", (c % 3 == 0) ? 1000 : (c % 3 == 1) ? 500 : 150, timer_tc_ms);
          chk("cc full", 100, cc_limit_pct);
        end
        else
          chk("cc", (c == 0) ? 100 : (c < 3) ? 100 - 10 * c : 90 - 5 * c, cc_limit_pct);
      end
    rd(OFS_SETTING, d, r);
    chk("setting", 32'h3200_0008, d);
    rd(8'h40, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    wr(OFS_CTRL, 32'h0);
    wt(0, 1'b0, 20, n);
    wr(OFS_CTRL, 32'h1);
    wt(0, 1'b1, 100, n);
    $display("settings test done");
    for (int v = 2; v >= 0; v--)
      for (f = F_AUX_VOLTAGE_SENSE_PIN; f <= F_INT; f++)
      begin
        flt <= 12'h001 << f;
        boot(v, 0);
        wt(3, 1'b1, 200, n);
        chk("latched", v != 2, fault_latched);
        chk("no pwm", 0, pwm_enable);
        chk("ovp sel", v == 2, supply_ovp_low_sel);
      end
    wt(4, 1'b1, 300, n);
    wt(4, 1'b0, 300, n);
    ac_present <= 1'b0;
    flt <= 12'h000;
    wt(1, 1'b0, 5, n);
    ac_present <= 1'b1;
    wt(0, 1'b1, 200, n);
    flt <= 12'h001 << F_DRV;
    boot(2, 0);
    wt(2, 1'b1, 300, n);
    wt(2, 1'b0, 300, n);
    wt(2, 1'b1, 300, n);
    flt <= 12'h000;
    wt(0, 1'b1, 500, n);
    $display("start-up fault test done");
    for (int i = 0; i < 5; i++)
      for (int v = 0; v < 2; v++)
      begin
        f = (i == 0) ? F_VDD_OV : (i == 1) ? F_VDD_UV : i + 1;
        boot(v, 0);
        wt(0, 1'b1, 100, n);
        flt <= 12'h001 << f;
        repeat (FILT_CYC - 20) @(posedge mclk);
        @(negedge mclk);
        chk("early", 1, pwm_enable);
        wt(0, 1'b0, 300, n);
        chk("latch", v == 0 && f != F_VDD_UV, fault_latched);
        rd(OFS_FAULT, d, r);
        chk("cause", 32'h1 << f, d & 32'hFFF);
        if (!(v == 0 && f != F_VDD_UV))
        begin
          wt(2, 1'b1, 300, n);
          chk("long delay", 1, n >= LONG - 3 && n <= LONG + 3);
        end
        flt <= 12'h000;
      end
    $display("filtered fault test done");
    boot(0, 0);
    wt(0, 1'b1, 100, n);
    flt <= 12'h001 << F_BROWN;
    repeat (45) @(posedge mclk);
    @(negedge mclk);
    chk("brownout early", 1, pwm_enable);
    wt(0, 1'b0, 30, n);
    wt(2, 1'b1, 300, n);
    chk("short delay", 1, n >= SHORT - 3 && n <= SHORT + 3);
    chk("brownout auto", 0, fault_latched);
    flt <= 12'h000;
    load_sq <= 16'hFFFF;
    boot(1, 2);
    wt(0, 1'b1, 100, n);
    repeat (10000) @(posedge mclk);
    @(negedge mclk);
    chk("no overload", 1, pwm_enable);
    boot(0, 2);
    wt(0, 1'b1, 100, n);
    wt(0, 1'b0, 20000, n);
    chk("overload auto", 0, fault_latched);
    $display("brownout and overload test done");
    stop_test();
  end
endmodule // ffm_fault_manager_tb_top
